// ===== core/counter_array_regs.svh
// register layout, reset values and timebase constants of the counter array
`ifndef COUNTER_ARRAY_REGS_SVH
`define COUNTER_ARRAY_REGS_SVH

`define CA_REG_WIDTH 8
`define CA_CNT_WIDTH 16
`define CA_NUM_MODULES 6

`define CA_CTRL_CF_BIT 7
`define CA_CTRL_CR_BIT 6
`define CA_CTRL_CCF_MSB 5
`define CA_CTRL_CCF_LSB 0
`define CA_CTRL_RESET 8'h00

`define CA_MODE_IDLE_SUSPEND_BIT 7
`define CA_MODE_UNUSED_MSB 6
`define CA_MODE_UNUSED_LSB 4
`define CA_MODE_CPS_MSB 3
`define CA_MODE_CPS_LSB 1
`define CA_MODE_ECF_BIT 0
`define CA_MODE_WMASK 8'h8F
`define CA_MODE_RESET 8'h00

`define CA_CNT_RESET 16'h0000
`define CA_CNT_MAX 16'hFFFF
`define CA_CNT_STEP 16'h0001

`define CA_TB_DIV2 3'h0
`define CA_TB_DIV4 3'h1
`define CA_TB_TIMER0 3'h2
`define CA_TB_EXT_FALL 3'h3
`define CA_TB_SYSCLK 3'h4
`define CA_TB_OSC_DIV8 3'h5
`define CA_TB_RSVD6 3'h6
`define CA_TB_RSVD7 3'h7

`define CA_DIV4_LAST 2'h3
`define CA_DIV4_STEP 2'h1
`define CA_OSC_DIV_LAST 3'h7
`define CA_OSC_DIV_STEP 3'h1

`endif

// ===== core/counter_array_pkg.sv
// types shared by the counter array control logic
package counter_array_pkg;
  `include "counter_array_regs.svh"

  typedef enum logic [2:0] {
    tb_div2 = `CA_TB_DIV2,
    tb_div4 = `CA_TB_DIV4,
    tb_timer0 = `CA_TB_TIMER0,
    tb_ext_fall = `CA_TB_EXT_FALL,
    tb_sysclk = `CA_TB_SYSCLK,
    tb_osc_div8 = `CA_TB_OSC_DIV8,
    tb_rsvd6 = `CA_TB_RSVD6,
    tb_rsvd7 = `CA_TB_RSVD7
  } timebase_type;

  typedef struct packed {
    logic [`CA_REG_WIDTH-1:0] control;
    logic [`CA_REG_WIDTH-1:0] mode;
    logic [`CA_CNT_WIDTH-1:0] count;
  } array_state_type;

  typedef struct packed {
    logic ext_meta;
    logic ext_sync;
    logic ext_last;
    logic osc_meta;
    logic osc_sync;
    logic osc_last;
    logic div2;
    logic [1:0] div4;
    logic [2:0] osc_div;
  } timebase_state_type;
endpackage

// ===== core/counter_array_timebase.sv
// timebase tick generator for the counter array
`timescale 1ns/1ps
`include "counter_array_regs.svh"
module counter_array_timebase (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire counter_array_pkg::timebase_type select_in,
  input wire logic timer0_overflow_in,
  input wire logic external_count_input_in,
  input wire logic external_osc_in,
  output logic tick_out
);
  import counter_array_pkg::*;

  timebase_state_type s_q, s_d;
  logic ext_fall, osc_rise;

  always_comb begin
    s_d = s_q;
    // two-stage synchronisers for the pins
    s_d.ext_meta = external_count_input_in;
    s_d.ext_sync = s_q.ext_meta;
    s_d.ext_last = s_q.ext_sync;
    s_d.osc_meta = external_osc_in;
    s_d.osc_sync = s_q.osc_meta;
    s_d.osc_last = s_q.osc_sync;
    ext_fall = s_q.ext_last & ~s_q.ext_sync;
    osc_rise = s_q.osc_sync & ~s_q.osc_last;
    s_d.div2 = ~s_q.div2;
    s_d.div4 = s_q.div4 + `CA_DIV4_STEP;
    if (osc_rise) begin
      s_d.osc_div = s_q.osc_div + `CA_OSC_DIV_STEP;
    end
    case (select_in)
      tb_div2: tick_out = s_q.div2;
      tb_div4: tick_out = (s_q.div4 == `CA_DIV4_LAST);
      tb_timer0: tick_out = timer0_overflow_in;
      tb_ext_fall: tick_out = ext_fall;
      tb_sysclk: tick_out = 1'b1;
      tb_osc_div8: tick_out = osc_rise && (s_q.osc_div == `CA_OSC_DIV_LAST);
      default: tick_out = 1'b0;
    endcase
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);

  a_div2_alternate: assert property (
    $past(arst_n_in) && (select_in == tb_div2) &&
      $past(select_in == tb_div2) |-> tick_out != $past(tick_out))
    else $error("divide-by-2 tick does not alternate");

  a_div4_spacing: assert property (
    (select_in == tb_div4) && tick_out ##1 (select_in == tb_div4) [*3]
      |-> !tick_out && !$past(tick_out, 1) && !$past(tick_out, 2))
    else $error("divide-by-4 tick spaced wrongly");

  a_reserved_no_tick: assert property (
    (select_in == tb_rsvd6) || (select_in == tb_rsvd7) |-> !tick_out)
    else $error("reserved timebase produced a tick");
endmodule

// ===== core/counter_array_control_mode_regs.sv
// control and mode registers with the 16-bit counter of the counter array
// Operation
// - counter rolling from FFFF to 0000 sets the overflow flag, bit 7.
// - run bit 6 at 0 holds the counter; at 1 it counts each tick.
// - bits 0..5 are module flags, set on that module's match or capture.
// - enabled module flag requests the shared interrupt; software clears it.
// - idle-suspend 0 keeps the array running during processor idle.
// - idle-suspend 1 halts the array while idle, resuming afterwards.
// - mode bits 6..4 read zero; writes to them are ignored.
// - timebase field picks sysclk/2, /4, timer 0, ext falls, sysclk, osc/8.
`timescale 1ns/1ps
`include "counter_array_regs.svh"
module counter_array_control_mode_regs (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic control_wr_in,
  input wire logic mode_wr_in,
  input wire logic [`CA_REG_WIDTH-1:0] wdata_in,
  input wire logic [`CA_NUM_MODULES-1:0] match_capture_evt_in,
  input wire logic [`CA_NUM_MODULES-1:0] module_irq_enable_in,
  input wire logic idle_in,
  input wire logic timer0_overflow_in,
  input wire logic external_count_input_in,
  input wire logic external_osc_in,
  output logic [`CA_REG_WIDTH-1:0] control_out,
  output logic [`CA_REG_WIDTH-1:0] mode_out,
  output logic [`CA_CNT_WIDTH-1:0] counter_array_out,
  output logic counter_tick_out,
  output logic array_active_out,
  output logic irq_out
);
  import counter_array_pkg::*;

  array_state_type s_q, s_d;
  logic tick;
  logic active;
  logic run;
  logic [`CA_NUM_MODULES-1:0] events;

  function automatic timebase_type timebase_of(
    input logic [`CA_REG_WIDTH-1:0] mode
  );
    timebase_of = timebase_type'(mode[`CA_MODE_CPS_MSB:`CA_MODE_CPS_LSB]);
  endfunction

  counter_array_timebase timebase_inst (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .select_in(timebase_of(s_q.mode)),
    .timer0_overflow_in(timer0_overflow_in),
    .external_count_input_in(external_count_input_in),
    .external_osc_in(external_osc_in),
    .tick_out(tick)
  );

  always_comb begin
    s_d = s_q;
    // idle only suspends when the idle-suspend bit is set
    active = !(s_q.mode[`CA_MODE_IDLE_SUSPEND_BIT] && idle_in);
    run = s_q.control[`CA_CTRL_CR_BIT] && active;
    events = active ? match_capture_evt_in : '0;
    if (control_wr_in) begin
      s_d.control = wdata_in;
    end
    if (mode_wr_in) begin
      s_d.mode = wdata_in & `CA_MODE_WMASK;
    end
    // hardware sets are applied after the write so they win
    s_d.control[`CA_CTRL_CCF_MSB:`CA_CTRL_CCF_LSB] =
      s_d.control[`CA_CTRL_CCF_MSB:`CA_CTRL_CCF_LSB] | events;
    if (run && tick) begin
      s_d.count = s_q.count + `CA_CNT_STEP;
      if (s_q.count == `CA_CNT_MAX) begin
        s_d.control[`CA_CTRL_CF_BIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_q.control <= `CA_CTRL_RESET;
      s_q.mode <= `CA_MODE_RESET;
      s_q.count <= `CA_CNT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign control_out = s_q.control;
  assign mode_out = s_q.mode;
  assign counter_array_out = s_q.count;
  assign counter_tick_out = run && tick;
  assign array_active_out = active;
  // flags stay set through vectoring; only a register write clears them
  assign irq_out =
    (s_q.control[`CA_CTRL_CF_BIT] && s_q.mode[`CA_MODE_ECF_BIT]) ||
    (|(s_q.control[`CA_CTRL_CCF_MSB:`CA_CTRL_CCF_LSB] &
       module_irq_enable_in));

  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);

  sequence roll_over;
    run && tick && (s_q.count == `CA_CNT_MAX);
  endsequence

  sequence idle_held;
    s_q.mode[`CA_MODE_IDLE_SUSPEND_BIT] && idle_in;
  endsequence

  a_overflow_sets_flag: assert property (
    roll_over |=> control_out[`CA_CTRL_CF_BIT] &&
      (counter_array_out == `CA_CNT_RESET))
    else $error("rollover did not set overflow flag");

  a_overflow_irq_out: assert property (
    control_out[`CA_CTRL_CF_BIT] && mode_out[`CA_MODE_ECF_BIT] |-> irq_out)
    else $error("overflow flag with enable gave no interrupt");

  a_flag_stays_set: assert property (
    control_out[`CA_CTRL_CF_BIT] && !control_wr_in
      |=> control_out[`CA_CTRL_CF_BIT])
    else $error("overflow flag cleared without a write");

  a_run_holds_count: assert property (
    !s_q.control[`CA_CTRL_CR_BIT] |=> $stable(counter_array_out))
    else $error("counter moved while stopped");

  a_run_advances: assert property (
    counter_tick_out |=>
      counter_array_out == 16'($past(counter_array_out) + `CA_CNT_STEP))
    else $error("counter did not advance on tick");

  a_flag_set_wins: assert property (
    |events |=> (control_out[`CA_CTRL_CCF_MSB:`CA_CTRL_CCF_LSB] &
      $past(events)) == $past(events))
    else $error("module event did not set its flag");

  a_module_irq_out: assert property (
    |(control_out[`CA_CTRL_CCF_MSB:`CA_CTRL_CCF_LSB] &
      module_irq_enable_in) |-> irq_out)
    else $error("enabled module flag gave no interrupt");

  a_idle_keeps_running: assert property (
    !mode_out[`CA_MODE_IDLE_SUSPEND_BIT] && control_out[`CA_CTRL_CR_BIT] && tick
      |-> counter_tick_out && array_active_out)
    else $error("array stopped with idle-suspend clear");

  a_idle_halts_all: assert property (
    idle_held ##1 idle_held |-> $stable(counter_array_out) &&
      !counter_tick_out && !array_active_out)
    else $error("array ran while suspended in idle");

  a_unused_mode_zero: assert property (
    mode_out[`CA_MODE_UNUSED_MSB:`CA_MODE_UNUSED_LSB] == 3'h0)
    else $error("unused mode bits not zero");

  a_clear_by_write: assert property (
    control_wr_in && !(|events) && !counter_tick_out
      |=> control_out == $past(wdata_in))
    else $error("control write not taken");

  a_mode_write_taken: assert property (
    mode_wr_in |=> mode_out == ($past(wdata_in) & `CA_MODE_WMASK))
    else $error("mode write not taken with unused bits masked");

  a_mode_holds: assert property (
    !mode_wr_in |=> $stable(mode_out))
    else $error("mode register changed without a write");

  a_overflow_only_roll: assert property (
    !control_wr_in &&
      !(counter_tick_out && (counter_array_out == `CA_CNT_MAX))
      |=> control_out[`CA_CTRL_CF_BIT] ==
        $past(control_out[`CA_CTRL_CF_BIT]))
    else $error("overflow flag moved without rollover or write");

  a_tick_needs_run: assert property (
    counter_tick_out |-> control_out[`CA_CTRL_CR_BIT] && array_active_out)
    else $error("counter ticked while stopped");

  a_no_tick_holds: assert property (
    !counter_tick_out |=> $stable(counter_array_out))
    else $error("counter moved without a tick");

  a_idle_blocks_events: assert property (
    idle_held ##0 !control_wr_in |=>
      control_out[`CA_CTRL_CCF_MSB:`CA_CTRL_CCF_LSB] ==
        $past(control_out[`CA_CTRL_CCF_MSB:`CA_CTRL_CCF_LSB]))
    else $error("module flag set while suspended in idle");

  a_flags_accumulate: assert property (
    !control_wr_in |=>
      control_out[`CA_CTRL_CCF_MSB:`CA_CTRL_CCF_LSB] ==
        ($past(control_out[`CA_CTRL_CCF_MSB:`CA_CTRL_CCF_LSB]) |
         $past(events)))
    else $error("module flags not old flags plus events");

  a_irq_held: assert property (
    irq_out && !control_wr_in && !mode_wr_in ##1
      $stable(module_irq_enable_in) |-> irq_out)
    else $error("interrupt request dropped without a write");

  a_reserved_no_count: assert property (
    (timebase_of(mode_out) == tb_rsvd6) ||
      (timebase_of(mode_out) == tb_rsvd7) |-> !counter_tick_out)
    else $error("reserved timebase advanced the counter");

  a_sysclk_ticks: assert property (
    (timebase_of(mode_out) == tb_sysclk) &&
      control_out[`CA_CTRL_CR_BIT] && array_active_out |-> counter_tick_out)
    else $error("system clock timebase missed a tick");

  a_timer0_ticks: assert property (
    (timebase_of(mode_out) == tb_timer0) &&
      control_out[`CA_CTRL_CR_BIT] && array_active_out
      |-> counter_tick_out == timer0_overflow_in)
    else $error("timer 0 timebase tick mismatch");

  a_active_unsuspended: assert property (
    !mode_out[`CA_MODE_IDLE_SUSPEND_BIT] |-> array_active_out)
    else $error("array inactive with idle-suspend clear");
endmodule

// ===== testbench/counter_array_control_mode_regs_bench.sv
// self-checking bench for the counter array control and mode registers
`timescale 1ns/1ps
`include "counter_array_regs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module counter_array_control_mode_regs_bench;
  logic clock_in = 0, arst_n_in = 0, control_wr_in = 0, mode_wr_in = 0;
  logic [7:0] wdata_in = 8'h00;
  logic [5:0] match_capture_evt_in = 6'h00, module_irq_enable_in = 6'h00;
  logic idle_in = 0, timer0_overflow_in = 0;
  logic external_count_input_in = 0, external_osc_in = 0;
  logic [7:0] control_out, mode_out;
  logic [15:0] counter_array_out, c0;
  logic counter_tick_out, array_active_out, irq_out;
  logic [31:0] rnd = 32'h17C1;
  logic [5:0] e;
  int bad_count = 0, checks_done = 0, i;
  integer t;
  counter_array_control_mode_regs uut (.clock_in(clock_in),
    .arst_n_in(arst_n_in), .control_wr_in(control_wr_in),
    .mode_wr_in(mode_wr_in), .wdata_in(wdata_in),
    .match_capture_evt_in(match_capture_evt_in),
    .module_irq_enable_in(module_irq_enable_in), .idle_in(idle_in),
    .timer0_overflow_in(timer0_overflow_in),
    .external_count_input_in(external_count_input_in),
    .external_osc_in(external_osc_in), .control_out(control_out),
    .mode_out(mode_out), .counter_array_out(counter_array_out),
    .counter_tick_out(counter_tick_out),
    .array_active_out(array_active_out), .irq_out(irq_out));
  always #10 clock_in = ~clock_in;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic int exp_ticks(input int sel);
    case (sel)
      0: return 36;
      1: return 18;
      4: return 72;
      2, 3: return 4;
      5: return 2;
      default: return 0;
    endcase
  endfunction
  task automatic cyc();
    @(posedge clock_in);
    #1;
  endtask
  task automatic wr(input logic ctl, input logic [7:0] d);
    control_wr_in = ctl;
    mode_wr_in = !ctl;
    wdata_in = d;
    cyc();
    control_wr_in = 0;
    mode_wr_in = 0;
    cyc();
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) cyc();
    arst_n_in = 1;
    `CHK({control_out, mode_out, counter_array_out}, 32'h0)
    `CHK({irq_out, array_active_out}, 2'h1)
    $display("reset test done");
    wr(0, 8'hFF);
    `CHK(mode_out, 8'h8F)
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      wr(0, rnd[7:0]);
      `CHK(mode_out, rnd[7:0] & 8'h8F)
    end
    $display("mode mask test done");
    for (int s = 0; s < 8; s++) begin
      wr(0, {4'h0, s[2:0], 1'b0});
      wr(1, 8'h40);
      c0 = counter_array_out;
      t = 0;
      for (i = 0; i < 72; i++) begin
        timer0_overflow_in = (s == 2 && i % 5 == 0 && i < 20);
        external_count_input_in = (s == 3 && i % 8 < 4 && i < 32);
        external_osc_in = (s == 5 && (i / 2) % 2 == 1 && i < 64);
        t += counter_tick_out;
        cyc();
      end
      `CHK(t, exp_ticks(s))
      `CHK(counter_array_out - c0, t[15:0])
      wr(1, 8'h00);
      c0 = counter_array_out;
      repeat (4) cyc();
      `CHK(counter_array_out, c0)
    end
    $display("timebase test done");
    e = 6'h00;
    for (i = 0; i < 20; i++) begin
      rnd = lfsr(rnd);
      match_capture_evt_in = rnd[5:0] & rnd[13:8];
      module_irq_enable_in = rnd[21:16];
      cyc();
      e |= match_capture_evt_in;
      `CHK(control_out[5:0], e)
      `CHK(irq_out, |(e & module_irq_enable_in))
    end
    match_capture_evt_in = 6'h04;
    wr(1, 8'h00);
    match_capture_evt_in = 6'h00;
    `CHK(control_out, 8'h04)
    $display("flag test done");
    wr(0, 8'h88);
    wr(1, 8'h40);
    idle_in = 1;
    c0 = counter_array_out;
    match_capture_evt_in = 6'h3F;
    cyc();
    `CHK(array_active_out, 1'h0)
    repeat (3) cyc();
    match_capture_evt_in = 6'h00;
    `CHK({control_out, counter_array_out}, {8'h40, c0})
    wr(0, 8'h08);
    c0 = counter_array_out;
    repeat (8) cyc();
    `CHK(counter_array_out - c0, 16'h0008)
    idle_in = 0;
    $display("idle test done");
    wr(0, 8'h09);
    for (i = 0; i < 70000 && counter_array_out !== 16'hFFFF; i++) cyc();
    if (i == 70000) begin
      bad_count++;
      end_sim();
    end
    cyc();
    `CHK({control_out[7], counter_array_out}, {1'b1, 16'h0000})
    `CHK(irq_out, 1'b1)
    wr(1, 8'h00);
    `CHK({control_out, irq_out}, 9'h000)
    $display("overflow test done");
    end_sim();
  end
endmodule
